// [rtl/user_kernel_address_partition.sv]
// User and kernel address partition decoder with AHB-Lite registers
//
// Summary of operation
// - Lower 2 GB virtual is user space, upper 2 GB kernel.
// - First fetch after reset goes to 0xBFC0_0000, uncached.
// - Kernel flash at 0x1D000000; user flash 0x7D000000 plus base.
// - Kernel RAM at zero; user RAM at 0x7F000000 plus base.
// - Until bases are written, flash and RAM are kernel only.
// - Kernel flash at 0xBD000000 uncached, 0x9D000000 cached.
// - Cached alias may cache and prefetch; uncached bypasses.
// - User flash base clears on reset: no user flash.
// - User flash spans 0x7D000000 plus base to flash top.
// - Kernel flash from flash bottom to below user base.
// - RAM order: kernel data, kernel prog, user data, user prog.
// - RAM fetch allowed only in program partitions.
// - Reset puts all RAM in kernel data, starting at zero.
// - Three bases mark the ends of the lower partitions.
// - Kernel mode reaches all memory.
// - Low eleven base bits read zero: 2 KB steps.
// - Flash total size is static and read-only.
//
// Chosen here: the AHB-Lite register port and the address map.
`timescale 1ns/1ps
`include "addr_part_map.svh"

module user_kernel_address_partition #(
    parameter logic [31:0] FLASH_SIZE     = `FLASH_SIZE_DEF,
    parameter logic [31:0] RAM_SIZE       = `RAM_SIZE_DEF,
    parameter int          FLASH_BASE_MSB = 19,
    parameter int          RAM_BASE_MSB   = 15
) (
    // Clock, reset, enable
    input  wire logic                        hclk,
    input  wire logic                        hresetn,
    input  wire logic                        clk_en,
    // AHB-Lite slave
    input  wire logic                        hsel,
    input  wire logic [31:0]                 haddr,
    input  wire logic [1:0]                  htrans,
    input  wire logic                        hwrite,
    input  wire logic [2:0]                  hsize,
    input  wire logic [31:0]                 hwdata,
    input  wire logic                        hready,
    output logic      [31:0]                 hrdata,
    output logic                             hreadyout,
    output logic                             hresp,
    // CPU access request
    input  wire logic                        cpu_valid,
    input  wire logic [31:0]                 cpu_vaddr,
    input  wire logic                        cpu_user,
    input  wire logic                        cpu_fetch,
    // Decoded access
    output logic                             dec_valid,
    output logic [31:0]                      dec_paddr,
    output addr_part_pkg::mem_target_type    dec_target,
    output addr_part_pkg::ram_region_type    dec_ram_region,
    output logic                             dec_cacheable,
    output logic                             dec_addr_err,
    output logic                             dec_bus_err,
    output logic                             dec_fetch_err,
    // Core setup
    output logic [31:0]                      reset_fetch_addr,
    output logic [`WAIT_MSB:0]               flash_wait_states
);

    import addr_part_pkg::*;

    // ------------------------------------------------------------------
    // Bus slave
    // ------------------------------------------------------------------
    logic        dphase_r;
    logic        dwrite_r;
    logic [7:0]  daddr_r;
    logic [31:0] hrdata_r;
    logic        hreadyout_r;
    logic        hresp_r;
    wire         aphase = hsel & htrans[1] & hready;
    wire         wr_act = dphase_r & dwrite_r;

    wire wr_kprog = wr_act & (daddr_r == `OFS_RAM_KPROG_BASE);
    wire wr_udata = wr_act & (daddr_r == `OFS_RAM_UDATA_BASE);
    wire wr_uprog = wr_act & (daddr_r == `OFS_RAM_UPROG_BASE);
    wire wr_fbase = wr_act & (daddr_r == `OFS_FLASH_UPROG_BASE);
    wire wr_cache = wr_act & (daddr_r == `OFS_CACHE_CONTROL);
    wire wr_cause = wr_act & (daddr_r == `OFS_FAULT_CAUSE);

    // ------------------------------------------------------------------
    // Partition base registers
    // ------------------------------------------------------------------
    logic [31:0] ram_kernel_prog_base;
    logic [31:0] ram_user_data_base;
    logic [31:0] ram_user_prog_base;
    logic [31:0] flash_user_prog_base;
    logic [31:0] kprog_nxt;
    logic [31:0] udata_nxt;
    logic [31:0] uprog_nxt;
    logic [31:0] fbase_nxt;

    part_base_reg #(.MSB(RAM_BASE_MSB)) u_kprog (
        .hclk      (hclk),
        .hresetn   (hresetn),
        .clk_en    (clk_en),
        .wr_en     (wr_kprog),
        .wdata     (hwdata),
        .value     (ram_kernel_prog_base),
        .value_nxt (kprog_nxt)
    );

    part_base_reg #(.MSB(RAM_BASE_MSB)) u_udata (
        .hclk      (hclk),
        .hresetn   (hresetn),
        .clk_en    (clk_en),
        .wr_en     (wr_udata),
        .wdata     (hwdata),
        .value     (ram_user_data_base),
        .value_nxt (udata_nxt)
    );

    part_base_reg #(.MSB(RAM_BASE_MSB)) u_uprog (
        .hclk      (hclk),
        .hresetn   (hresetn),
        .clk_en    (clk_en),
        .wr_en     (wr_uprog),
        .wdata     (hwdata),
        .value     (ram_user_prog_base),
        .value_nxt (uprog_nxt)
    );

    part_base_reg #(.MSB(FLASH_BASE_MSB)) u_fbase (
        .hclk      (hclk),
        .hresetn   (hresetn),
        .clk_en    (clk_en),
        .wr_en     (wr_fbase),
        .wdata     (hwdata),
        .value     (flash_user_prog_base),
        .value_nxt (fbase_nxt)
    );

    // ------------------------------------------------------------------
    // Flash partition limits
    // ------------------------------------------------------------------
    // zero base means all kernel
    wire         fbase_set = (flash_user_prog_base != `WORD_ZERO);
    // kernel flash ends below user base
    wire [31:0]  kflash_lim = fbase_set ? flash_user_prog_base : FLASH_SIZE;

    // ------------------------------------------------------------------
    // RAM partition limits
    // ------------------------------------------------------------------
    wire kp_set = (ram_kernel_prog_base != `WORD_ZERO);
    wire ud_set = (ram_user_data_base != `WORD_ZERO);
    wire up_set = (ram_user_prog_base != `WORD_ZERO);
    wire [31:0] ud_end = up_set ? ram_user_prog_base : RAM_SIZE;
    wire [31:0] kp_end = ud_set ? ram_user_data_base : ud_end;
    wire [31:0] kd_end = kp_set ? ram_kernel_prog_base : kp_end;

    // ------------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------------
    // top bit splits user and kernel
    wire        in_user   = ~cpu_vaddr[31];
    wire        in_kseg01 = (cpu_vaddr[31:30] == 2'b10);
    // cached alias has bit 29 clear
    wire        in_cached_kernel_segment  = in_kseg01 & ~cpu_vaddr[29];
    wire [31:0] kphys     = cpu_vaddr & `KPHYS_MASK;
    wire [31:0] uphys     = cpu_vaddr + `USER_PHYS_OFS;

    // kernel flash at fixed physical base
    wire [31:0] kf_off   = kphys - `KFLASH_PBASE;
    wire        hit_kfl  = in_kseg01 & (kphys >= `KFLASH_PBASE)
                         & (kf_off < kflash_lim);
    // user flash from base to top of flash
    wire [31:0] uf_off   = cpu_vaddr - `UFLASH_VBASE;
    wire        hit_ufl  = in_user & fbase_set
                         & (cpu_vaddr >= `UFLASH_VBASE)
                         & (uf_off >= flash_user_prog_base)
                         & (uf_off < FLASH_SIZE);

    wire [31:0] ur_off   = cpu_vaddr - `URAM_VBASE;
    wire [31:0] ram_off  = in_user ? ur_off : kphys;

    ram_region_type region;
    assign region = (ram_off < kd_end)          ? RAM_KDATA :
                    (kp_set & (ram_off < kp_end)) ? RAM_KPROG :
                    (ud_set & (ram_off < ud_end)) ? RAM_UDATA :
                    up_set                       ? RAM_UPROG : RAM_KDATA;
    wire        user_part = (region == RAM_UDATA) | (region == RAM_UPROG);

    wire        hit_kram = in_kseg01 & (kphys < RAM_SIZE);
    wire        hit_uram = in_user & (cpu_vaddr >= `URAM_VBASE)
                         & (ur_off < RAM_SIZE) & user_part;
    wire        hit_ram  = hit_kram | hit_uram;

    wire [31:0] bt_off   = kphys - `BOOT_PBASE;
    wire        hit_boot = in_kseg01 & (kphys >= `BOOT_PBASE)
                         & (bt_off < `BOOT_SIZE);
    wire [31:0] pr_off   = kphys - `PERIPH_PBASE;
    wire        hit_per  = in_kseg01 & (kphys >= `PERIPH_PBASE)
                         & (pr_off < `PERIPH_SIZE);

    wire        addr_err = cpu_user & cpu_vaddr[31];
    wire        hit_any  = hit_kfl | hit_ufl | hit_ram | hit_boot | hit_per;
    wire        bus_err  = ~addr_err & ~hit_any;
    wire        fetch_err = ~addr_err & cpu_fetch & hit_ram
                          & ((region == RAM_KDATA) | (region == RAM_UDATA));
    wire        fault    = addr_err | bus_err | fetch_err;

    mem_target_type target;
    assign target = (addr_err | bus_err) ? TGT_NONE :
                    (hit_kfl | hit_ufl)   ? TGT_FLASH :
                    hit_ram               ? TGT_RAM :
                    hit_boot              ? TGT_BOOT : TGT_PERIPH;
    wire [31:0] paddr = in_user ? uphys : kphys;
    wire        cacheable = ~fault & hit_kfl & in_cached_kernel_segment;

    // ------------------------------------------------------------------
    // Control and fault state
    // ------------------------------------------------------------------
    logic [`WAIT_MSB:0]  wait_r;
    logic [31:0]         fault_addr_r;
    logic [`CAUSE_W-1:0] cause_r;
    wire  [`WAIT_MSB:0]  wait_nxt = wr_cache ? hwdata[`WAIT_MSB:0] : wait_r;
    wire  [`CAUSE_W-1:0] cause_set = {`CAUSE_W{cpu_valid}}
                                   & {fetch_err, bus_err, addr_err};
    // Write one clears; set wins
    wire  [`CAUSE_W-1:0] cause_clr = wr_cause ? hwdata[`CAUSE_W-1:0]
                                              : {`CAUSE_W{1'b0}};
    wire  [`CAUSE_W-1:0] cause_nxt = (cause_r & ~cause_clr) | cause_set;
    wire  [31:0]         faddr_nxt = (cpu_valid & fault) ? cpu_vaddr
                                                         : fault_addr_r;

    // Read mux
    logic [31:0] rd_mux;
    always_comb begin
        case (haddr[7:0])
            `OFS_RAM_KPROG_BASE:   rd_mux = kprog_nxt;
            `OFS_RAM_UDATA_BASE:   rd_mux = udata_nxt;
            `OFS_RAM_UPROG_BASE:   rd_mux = uprog_nxt;
            `OFS_RAM_TOTAL_SIZE:   rd_mux = RAM_SIZE;
            `OFS_FLASH_UPROG_BASE: rd_mux = fbase_nxt;
            `OFS_FLASH_TOTAL_SIZE: rd_mux = FLASH_SIZE;
            `OFS_CACHE_CONTROL:
                rd_mux = {{(31-`WAIT_MSB){1'b0}}, wait_nxt};
            `OFS_FAULT_ADDR:       rd_mux = faddr_nxt;
            `OFS_FAULT_CAUSE:
                rd_mux = {{(32-`CAUSE_W){1'b0}}, cause_nxt};
            default:               rd_mux = `WORD_ZERO;
        endcase
    end

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    logic                 dec_valid_r;
    logic [31:0]          dec_paddr_r;
    mem_target_type       dec_target_r;
    ram_region_type       dec_region_r;
    logic                 dec_cache_r;
    logic                 dec_aerr_r;
    logic                 dec_berr_r;
    logic                 dec_ferr_r;
    logic [31:0]          reset_fetch_r;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dphase_r    <= 1'b0;
            dwrite_r    <= 1'b0;
            daddr_r     <= 8'h00;
            hrdata_r    <= `WORD_ZERO;
            hreadyout_r <= 1'b1;
            hresp_r     <= 1'b0;
        end else if (clk_en) begin
            dphase_r    <= aphase;
            dwrite_r    <= hwrite;
            daddr_r     <= haddr[7:0];
            hrdata_r    <= (aphase & ~hwrite) ? rd_mux : hrdata_r;
            hreadyout_r <= 1'b1;
            hresp_r     <= 1'b0;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wait_r       <= `WAIT_RESET;
            cause_r      <= '0;
            fault_addr_r <= `WORD_ZERO;
        end else if (clk_en) begin
            wait_r       <= wait_nxt;
            cause_r      <= cause_nxt;
            fault_addr_r <= faddr_nxt;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            reset_fetch_r <= `RESET_FETCH_VADDR;
            dec_valid_r   <= 1'b0;
            dec_paddr_r   <= `WORD_ZERO;
            dec_target_r  <= TGT_NONE;
            dec_region_r  <= RAM_KDATA;
            dec_cache_r   <= 1'b0;
            dec_aerr_r    <= 1'b0;
            dec_berr_r    <= 1'b0;
            dec_ferr_r    <= 1'b0;
        end else if (clk_en) begin
            dec_valid_r   <= cpu_valid;
            if (cpu_valid) begin
                dec_paddr_r  <= paddr;
                dec_target_r <= target;
                dec_region_r <= region;
                dec_cache_r  <= cacheable;
                dec_aerr_r   <= addr_err;
                dec_berr_r   <= bus_err;
                dec_ferr_r   <= fetch_err;
            end
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign hrdata            = hrdata_r;
    assign hreadyout         = hreadyout_r;
    assign hresp             = hresp_r;
    assign dec_valid         = dec_valid_r;
    assign dec_paddr         = dec_paddr_r;
    assign dec_target        = dec_target_r;
    assign dec_ram_region    = dec_region_r;
    assign dec_cacheable     = dec_cache_r;
    assign dec_addr_err      = dec_aerr_r;
    assign dec_bus_err       = dec_berr_r;
    assign dec_fetch_err     = dec_ferr_r;
    assign reset_fetch_addr  = reset_fetch_r;
    assign flash_wait_states = wait_r;

endmodule

// [rtl/addr_part_map.svh]
// Offsets, reset values and address constants of the partition decoder
`ifndef ADDR_PART_MAP_SVH
`define ADDR_PART_MAP_SVH

// ----------------------------------------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------------------------------------
`define OFS_RAM_KPROG_BASE   8'h00
`define OFS_RAM_UDATA_BASE   8'h04
`define OFS_RAM_UPROG_BASE   8'h08
`define OFS_RAM_TOTAL_SIZE   8'h0C
`define OFS_FLASH_UPROG_BASE 8'h10
`define OFS_FLASH_TOTAL_SIZE 8'h14
`define OFS_CACHE_CONTROL    8'h18
`define OFS_FAULT_ADDR       8'h1C
`define OFS_FAULT_CAUSE      8'h20

// ----------------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------------
`define BASE_LSB             11
`define WAIT_MSB             2
`define WAIT_RESET           3'h7
`define CAUSE_W              3
`define WORD_ZERO            32'h0000_0000

// ----------------------------------------------------------------------
// Address map
// ----------------------------------------------------------------------
`define RESET_FETCH_VADDR    32'hBFC0_0000
`define KPHYS_MASK           32'h1FFF_FFFF
`define KFLASH_PBASE         32'h1D00_0000
`define UFLASH_VBASE         32'h7D00_0000
`define URAM_VBASE           32'h7F00_0000
`define USER_PHYS_OFS        32'h4000_0000
`define BOOT_PBASE           32'h1FC0_0000
`define BOOT_SIZE            32'h0000_3000
`define PERIPH_PBASE         32'h1F80_0000
`define PERIPH_SIZE          32'h0010_0000
`define FLASH_SIZE_DEF       32'h0008_0000
`define RAM_SIZE_DEF         32'h0000_8000

`endif

// [rtl/addr_part_pkg.sv]
// Types shared by the partition decoder files
package addr_part_pkg;

    // Memory target of a decoded access
    typedef enum logic [4:0] {
        TGT_NONE   = 5'b00001,
        TGT_FLASH  = 5'b00010,
        TGT_RAM    = 5'b00100,
        TGT_BOOT   = 5'b01000,
        TGT_PERIPH = 5'b10000
    } mem_target_type;

    // Partition of data RAM
    typedef enum logic [3:0] {
        RAM_KDATA = 4'b0001,
        RAM_KPROG = 4'b0010,
        RAM_UDATA = 4'b0100,
        RAM_UPROG = 4'b1000
    } ram_region_type;

endpackage

// [rtl/part_base_reg.sv]
// One partition base register with 2 KB granularity
`timescale 1ns/1ps
`include "addr_part_map.svh"

module part_base_reg #(
    parameter int MSB = 15
) (
    // Clock and reset
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        clk_en,
    // Write port
    input  wire logic        wr_en,
    input  wire logic [31:0] wdata,
    // Value now and after this edge
    output logic      [31:0] value,
    output logic      [31:0] value_nxt
);

    logic [MSB:`BASE_LSB] base_r;
    logic [MSB:`BASE_LSB] base_nxt;

    assign base_nxt = wr_en ? wdata[MSB:`BASE_LSB] : base_r;

    assign value     = {{(31-MSB){1'b0}}, base_r, {`BASE_LSB{1'b0}}};
    assign value_nxt = {{(31-MSB){1'b0}}, base_nxt, {`BASE_LSB{1'b0}}};

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            base_r <= '0;
        end else if (clk_en) begin
            base_r <= base_nxt;
        end
    end

endmodule

// [testbench/user_kernel_address_partition_properties.sv]
// Concurrent checks on the decoder ports
`timescale 1ns/1ps
`include "addr_part_map.svh"

module user_kernel_address_partition_properties #(
    parameter logic [31:0] FLASH_SIZE = `FLASH_SIZE_DEF,
    parameter logic [31:0] RAM_SIZE   = `RAM_SIZE_DEF
) (
    // Clock and reset
    input wire logic                          hclk,
    input wire logic                          hresetn,
    input wire logic                          clk_en,
    // CPU request
    input wire logic                          cpu_valid,
    input wire logic [31:0]                   cpu_vaddr,
    input wire logic                          cpu_user,
    input wire logic                          cpu_fetch,
    // Decoded access
    input wire logic                          dec_valid,
    input wire logic [31:0]                   dec_paddr,
    input wire addr_part_pkg::mem_target_type dec_target,
    input wire addr_part_pkg::ram_region_type dec_ram_region,
    input wire logic                          dec_cacheable,
    input wire logic                          dec_addr_err,
    input wire logic                          dec_bus_err,
    input wire logic                          dec_fetch_err,
    // Core setup
    input wire logic [31:0]                   reset_fetch_addr
);
    import addr_part_pkg::*;

    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    sequence s_kern(logic [2:0] seg);
        cpu_valid && clk_en && !cpu_user && cpu_vaddr[31:29] == seg;
    endsequence

    sequence s_user;
        cpu_valid && clk_en && cpu_user;
    endsequence

    user_half_refuse_a: assert property (
        s_user ##0 cpu_vaddr[31] |=> dec_addr_err && dec_target == TGT_NONE)
        else $error("user kernel access");
    user_phys_map_a: assert property (
        s_user ##0 !cpu_vaddr[31] |=> !dec_addr_err
        && dec_paddr == $past(cpu_vaddr) + `USER_PHYS_OFS)
        else $error("user paddr");
    kern_phys_map_a: assert property (
        (s_kern(3'h4) or s_kern(3'h5)) |=> !dec_addr_err
        && dec_paddr == ($past(cpu_vaddr) & `KPHYS_MASK))
        else $error("kernel paddr");
    uncached_alias_a: assert property (
        s_kern(3'h5) |=> !dec_cacheable)
        else $error("uncached cacheable");
    cached_flash_a: assert property (
        dec_valid && dec_cacheable |-> dec_target == TGT_FLASH
        && ($past(cpu_vaddr) & 32'hFF00_0000) == 32'h9D00_0000)
        else $error("stray cacheable");
    kseg_high_err_a: assert property (
        (s_kern(3'h6) or s_kern(3'h7))
        |=> dec_bus_err && dec_target == TGT_NONE)
        else $error("upper segment fault");
    flash_gap_err_a: assert property (
        s_kern(3'h4) ##0 (cpu_vaddr[28:24] == 5'h1D
        && cpu_vaddr[23:0] >= FLASH_SIZE[23:0]) |=> dec_bus_err)
        else $error("flash gap fault");
    ram_gap_err_a: assert property (
        s_kern(3'h4) ##0 (cpu_vaddr[28:24] == 5'h00
        && cpu_vaddr[23:0] >= RAM_SIZE[23:0]) |=> dec_bus_err)
        else $error("ram gap fault");
    fetch_prog_only_a: assert property (
        dec_valid && dec_target == TGT_RAM |-> dec_fetch_err == ($past(
        cpu_fetch) && dec_ram_region inside {RAM_KDATA, RAM_UDATA}))
        else $error("ram fetch check");
    boot_decode_a: assert property (
        s_kern(3'h5) ##0 cpu_vaddr == reset_fetch_addr
        |=> dec_target == TGT_BOOT && dec_paddr == `BOOT_PBASE)
        else $error("reset vector decode");
    reset_vector_a: assert property (
        reset_fetch_addr == `RESET_FETCH_VADDR)
        else $error("reset fetch addr");
endmodule

bind user_kernel_address_partition user_kernel_address_partition_properties
    #(.FLASH_SIZE(FLASH_SIZE), .RAM_SIZE(RAM_SIZE)) u_props (
    .hclk(hclk), .hresetn(hresetn), .clk_en(clk_en),
    .cpu_valid(cpu_valid), .cpu_vaddr(cpu_vaddr), .cpu_user(cpu_user),
    .cpu_fetch(cpu_fetch), .dec_valid(dec_valid), .dec_paddr(dec_paddr),
    .dec_target(dec_target), .dec_ram_region(dec_ram_region),
    .dec_cacheable(dec_cacheable), .dec_addr_err(dec_addr_err),
    .dec_bus_err(dec_bus_err), .dec_fetch_err(dec_fetch_err),
    .reset_fetch_addr(reset_fetch_addr));

// [testbench/cpu_core_model.sv]
// Behavioural CPU core issuing user and kernel accesses
`timescale 1ns/1ps

module cpu_core_model (
    // Clock
    input wire logic   hclk,
    // Access request
    output logic        cpu_valid = 1'b0,
    output logic [31:0] cpu_vaddr = 32'h0000_0000,
    output logic        cpu_user  = 1'b0,
    output logic        cpu_fetch = 1'b0
);
    // One access; qualifiers scrambled once it drops
    task automatic issue(input logic [31:0] va, input logic usr, ftc);
        @(posedge hclk);
        cpu_valid <= 1'b1;
        cpu_vaddr <= va;
        cpu_user  <= usr;
        cpu_fetch <= ftc;
        @(posedge hclk);
        cpu_valid <= 1'b0;
        cpu_vaddr <= ~va;
        cpu_user  <= ~usr;
        cpu_fetch <= ~ftc;
    endtask
endmodule

// [testbench/user_kernel_address_partition_tb.sv]
// Self-checking bench for the partition decoder
`timescale 1ns/1ps
`include "addr_part_map.svh"

module user_kernel_address_partition_tb;
    import addr_part_pkg::*;

    logic           hclk = 1'b0, hresetn = 1'b0, clk_en = 1'b1;
    logic           hsel = 1'b0, hwrite = 1'b0;
    logic [1:0]     htrans = 2'h0;
    logic [2:0]     hsize = 3'h2;
    logic [31:0]    haddr = 32'h0000_0000, hwdata = 32'h0000_0000;
    logic [31:0]    hrdata, rd, cpu_vaddr, dec_paddr, reset_fetch_addr;
    logic           hreadyout, hresp, cpu_valid, cpu_user, cpu_fetch;
    logic           dec_valid, dec_cacheable, dec_addr_err;
    logic           dec_bus_err, dec_fetch_err;
    logic [2:0]     flash_wait_states;
    mem_target_type dec_target;
    ram_region_type dec_ram_region;
    int             bad_count = 0;
    int             checks = 0;

    always #2.5 hclk = ~hclk;

    user_kernel_address_partition uut (
        .hclk(hclk), .hresetn(hresetn), .clk_en(clk_en), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .cpu_valid(cpu_valid),
        .cpu_vaddr(cpu_vaddr), .cpu_user(cpu_user), .cpu_fetch(cpu_fetch),
        .dec_valid(dec_valid), .dec_paddr(dec_paddr),
        .dec_target(dec_target), .dec_ram_region(dec_ram_region),
        .dec_cacheable(dec_cacheable), .dec_addr_err(dec_addr_err),
        .dec_bus_err(dec_bus_err), .dec_fetch_err(dec_fetch_err),
        .reset_fetch_addr(reset_fetch_addr),
        .flash_wait_states(flash_wait_states));

    cpu_core_model cpu (
        .hclk(hclk), .cpu_valid(cpu_valid), .cpu_vaddr(cpu_vaddr),
        .cpu_user(cpu_user), .cpu_fetch(cpu_fetch));

    task automatic chk(input string nm, input logic [31:0] exp, got);
        checks++;
        if (got !== exp) begin
            bad_count++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic bus(input logic [7:0] a, input logic w,
                       input logic [31:0] wd);
        @(posedge hclk);
        hsel   <= 1'b1;
        haddr  <= {24'h00_0000, a};
        htrans <= 2'h2;
        hwrite <= w;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
        chk("hresp", 32'h0000_0000, {31'h0, hresp});
    endtask

    task automatic rchk(input string nm, input logic [7:0] a,
                        input logic [31:0] exp);
        bus(a, 1'b0, 32'h0000_0000);
        chk(nm, exp, rd);
    endtask

    // Mode bit 1 user, bit 0 fetch; flags {cache, fetch, bus, addr}
    task automatic acc(input logic [31:0] va, input logic [1:0] md,
                       input mem_target_type tg, input ram_region_type rg,
                       input logic [3:0] fl);
        logic [31:0] pa;
        pa = md[1] ? va + `USER_PHYS_OFS : va & `KPHYS_MASK;
        cpu.issue(va, md[1], md[0]);
        #1;
        chk("valid", 32'h0000_0001, {31'h0, dec_valid});
        chk("target", 32'(tg), 32'(dec_target));
        if (tg != TGT_NONE) chk("paddr", pa, dec_paddr);
        if (tg == TGT_RAM) chk("region", 32'(rg), 32'(dec_ram_region));
        chk("flags", {28'h0, fl}, {28'h0, dec_cacheable, dec_fetch_err,
            dec_bus_err, dec_addr_err});
    endtask

    task automatic do_reset;
        hresetn <= 1'b0;
        repeat (20) @(posedge hclk);
        hresetn <= 1'b1;
    endtask

    task automatic close_out;
        if (bad_count == 0 && checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    initial begin
        repeat (4000) @(posedge hclk);
        bad_count++;
        close_out;
    end

    initial begin
        do_reset;
        acc(32'hBFC0_0000, 2'h1, TGT_BOOT, RAM_KDATA, 4'h0);
        rchk("wait_states", 8'h18, 32'h0000_0007);
        rchk("fbase", 8'h10, 32'h0000_0000);
        rchk("fsize", 8'h14, `FLASH_SIZE_DEF);
        bus(8'h14, 1'b1, 32'hFFFF_FFFF);
        rchk("fsize", 8'h14, `FLASH_SIZE_DEF);
        rchk("unmapped", 8'h40, 32'h0000_0000);
        acc(32'h9D07_FFFC, 2'h0, TGT_FLASH, RAM_KDATA, 4'h8);
        acc(32'hBD00_0000, 2'h0, TGT_FLASH, RAM_KDATA, 4'h0);
        acc(32'h7D07_FFFC, 2'h2, TGT_NONE, RAM_KDATA, 4'h2);
        acc(32'h8000_7FFC, 2'h0, TGT_RAM, RAM_KDATA, 4'h0);
        acc(32'h8000_0000, 2'h1, TGT_RAM, RAM_KDATA, 4'h4);
        acc(32'h7F00_0000, 2'h2, TGT_NONE, RAM_KDATA, 4'h2);
        acc(32'h9D08_0000, 2'h0, TGT_NONE, RAM_KDATA, 4'h2);
        acc(32'h8000_8000, 2'h0, TGT_NONE, RAM_KDATA, 4'h2);
        acc(32'hC000_0000, 2'h0, TGT_NONE, RAM_KDATA, 4'h2);
        acc(32'h9D00_0000, 2'h2, TGT_NONE, RAM_KDATA, 4'h1);
        rchk("fault_addr", 8'h1C, 32'h9D00_0000);
        rchk("fault_cause", 8'h20, 32'h0000_0007);
        acc(32'hBF80_0000, 2'h0, TGT_PERIPH, RAM_KDATA, 4'h0);
        bus(8'h10, 1'b1, `FLASH_SIZE_DEF - 32'h0000_5000);
        rchk("fbase", 8'h10, 32'h0007_B000);
        acc(32'h7D07_B000, 2'h2, TGT_FLASH, RAM_KDATA, 4'h0);
        acc(32'h7D07_AFFC, 2'h2, TGT_NONE, RAM_KDATA, 4'h2);
        acc(32'h9D07_AFFC, 2'h0, TGT_FLASH, RAM_KDATA, 4'h8);
        acc(32'hBD07_B000, 2'h0, TGT_NONE, RAM_KDATA, 4'h2);
        bus(8'h00, 1'b1, 32'h0000_27FF);
        rchk("kprog_base", 8'h00, 32'h0000_2000);
        bus(8'h04, 1'b1, 32'h0000_4000);
        bus(8'h08, 1'b1, 32'h0000_6000);
        acc(32'h8000_1FFC, 2'h0, TGT_RAM, RAM_KDATA, 4'h0);
        acc(32'h8000_2000, 2'h1, TGT_RAM, RAM_KPROG, 4'h0);
        acc(32'h7F00_4000, 2'h2, TGT_RAM, RAM_UDATA, 4'h0);
        acc(32'h7F00_5FFC, 2'h3, TGT_RAM, RAM_UDATA, 4'h4);
        acc(32'h7F00_6000, 2'h3, TGT_RAM, RAM_UPROG, 4'h0);
        acc(32'h7F00_3FFC, 2'h2, TGT_NONE, RAM_KDATA, 4'h2);
        acc(32'h8000_4000, 2'h0, TGT_RAM, RAM_UDATA, 4'h0);
        bus(8'h18, 1'b1, 32'h0000_0002);
        #1;
        chk("wait_states", 32'h2, {29'h0, flash_wait_states});
        do_reset;
        rchk("fbase", 8'h10, 32'h0000_0000);
        rchk("kprog_base", 8'h00, 32'h0000_0000);
        acc(32'h7D07_B000, 2'h2, TGT_NONE, RAM_KDATA, 4'h2);
        acc(32'h8000_2000, 2'h1, TGT_RAM, RAM_KDATA, 4'h4);
        close_out;
    end
endmodule
